// >>> verilog/simss_defs.svh
/*
 * Constants of the servo input mapping and speed select block: register
 * offsets, reset values, function codes and speed limits.
 * Assumes a 32-bit classic Wishbone slave port and byte offsets.
 */
`ifndef SIMSS_DEFS_SVH
`define SIMSS_DEFS_SVH

`define SIMSS_OFF_FN_BASE   8'h00
`define SIMSS_OFF_FN9       8'h20
`define SIMSS_OFF_SW_EN     8'h24
`define SIMSS_OFF_JOG       8'h28
`define SIMSS_OFF_MODE      8'h2C
`define SIMSS_OFF_SPEED_SELECT_HIGH      8'h30
`define SIMSS_OFF_SPD2      8'h34
`define SIMSS_OFF_SPD3      8'h38
`define SIMSS_OFF_DISP      8'h3C
`define SIMSS_OFF_STATUS    8'h40
`define SIMSS_OFF_CMD       8'h44

`define SIMSS_RST_FN1       16'h0101
`define SIMSS_RST_FN2       16'h0109
`define SIMSS_RST_FN3       16'h0114
`define SIMSS_RST_FN4       16'h0115
`define SIMSS_RST_FN5       16'h0102
`define SIMSS_RST_FN6       16'h0022
`define SIMSS_RST_FN7       16'h0023
`define SIMSS_RST_FN8       16'h0021
`define SIMSS_RST_FN9       16'h0000
`define SIMSS_RST_JOG       16'h0014
`define SIMSS_RST_MODE      4'h0
`define SIMSS_RST_DISP      16'h0000

`define SIMSS_MODE_SPEED    4'h2
`define SIMSS_DISP_SPEED    16'h0006
`define SIMSS_POL_NO        8'h01
`define SIMSS_POL_NC        8'h00

`define SIMSS_ID_SON        8'h01
`define SIMSS_ID_ALARM_CLEAR_INPUT       8'h02
`define SIMSS_ID_TRQ        8'h09
`define SIMSS_ID_SPEED_SELECT_LOW       8'h14
`define SIMSS_ID_SPEED_SELECT_HIGH       8'h15
`define SIMSS_ID_EMG        8'h21
`define SIMSS_ID_NL         8'h22
`define SIMSS_ID_PL         8'h23

`define SIMSS_SPD_MAX       32'sh0000C350
`define SIMSS_SPD_MIN       32'shFFFF3CB0
`define SIMSS_JOG_SCALE     32'h0000000A

`endif

// >>> verilog/simss_pkg.sv
/*
 * Types shared by the servo input mapping block: function index, jog
 * state, speed source and the packed state record of the top module.
 * Assumes simss_defs.svh for the numeric constants.
 */
package simss_pkg;

    typedef enum logic [1:0]
    {
        SIMSS_JOG_IDLE = 2'h1,
        SIMSS_JOG_RUN  = 2'h2
    } simss_jog_t;

    typedef enum logic [3:0]
    {
        SIMSS_SRC_ANALOG = 4'h1,
        SIMSS_SRC_REG1   = 4'h2,
        SIMSS_SRC_REG2   = 4'h4,
        SIMSS_SRC_REG3   = 4'h8
    } simss_src_t;

    typedef enum int
    {
        SIMSS_FI_SON, SIMSS_FI_ALARM_CLEAR_INPUT, SIMSS_FI_TRQ, SIMSS_FI_SPEED_SELECT_LOW,
        SIMSS_FI_SPEED_SELECT_HIGH, SIMSS_FI_EMG, SIMSS_FI_NL, SIMSS_FI_PL
    } simss_fi_t;

    typedef struct packed
    {
        logic              ack;
        logic [31:0]       rdata;
        logic [8:0][15:0]  fn_code;
        logic              sw_en;
        logic [15:0]       jog_speed;
        logic              jog_armed;
        logic [3:0]        mode_param;
        logic [3:0]        mode_active;
        logic [2:0][31:0]  spd_reg;
        logic [15:0]       disp_param;
        simss_jog_t        jog;
        simss_src_t        src;
        logic              warn_emg;
        logic              warn_nl;
        logic              warn_pl;
        logic              alarm;
        logic              servo_on;
        logic              trq;
        logic [31:0]       speed_cmd;
        logic [31:0]       disp_val;
        logic              disp_spd;
        logic              spd_mode;
    } simss_state_t;

    function automatic logic [31:0] simss_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  sel
    );
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
            if (sel[b])
                r[8*b +: 8] = new_v[8*b +: 8];
        return r;
    endfunction : simss_merge

endpackage : simss_pkg

// >>> verilog/simss_di_decode.sv
/*
 * Maps nine digital inputs onto functions through their function codes;
 * low code byte names the function, next byte the contact polarity.
 * Assumes inputs are already synchronous to the clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "simss_defs.svh"

module simss_di_decode
    import simss_pkg::*;
(
    input  wire logic [8:0][15:0] fn_code,
    input  wire logic [8:0]       di,
    output logic      [7:0]       func_on
);

    localparam logic [7:0][7:0] FN_ID =
    {
        `SIMSS_ID_PL,   `SIMSS_ID_NL,   `SIMSS_ID_EMG,  `SIMSS_ID_SPEED_SELECT_HIGH,
        `SIMSS_ID_SPEED_SELECT_LOW, `SIMSS_ID_TRQ,  `SIMSS_ID_ALARM_CLEAR_INPUT, `SIMSS_ID_SON
    };

    logic [8:0]      act;
    logic [8:0]      pol_ok;
    logic [7:0][8:0] hit;

    for (genvar i = 0; i < 9; i++)
    begin : g_in
        // Normally open active high, normally closed active low
        assign act[i]    = (fn_code[i][15:8] == `SIMSS_POL_NO) ? di[i]
                                                               : ~di[i];
        assign pol_ok[i] = (fn_code[i][15:8] == `SIMSS_POL_NO) ||
                           (fn_code[i][15:8] == `SIMSS_POL_NC);
        for (genvar f = 0; f < 8; f++)
        begin : g_fn
            // Code zero matches no function id
            assign hit[f][i] = act[i] && pol_ok[i] &&
                               (fn_code[i][7:0] == FN_ID[f]);
        end
    end

    for (genvar f = 0; f < 8; f++)
    begin : g_or
        assign func_on[f] = |hit[f];
    end

endmodule : simss_di_decode
`default_nettype wire

// >>> verilog/simss_top.sv
/*
 * Servo input mapping and speed select: programmable input functions,
 * limit and halt warnings, alarm latch, servo enable, jog mode and
 * speed command source selection behind a classic Wishbone slave.
 * Assumes all inputs synchronous to clock; power_cycle_pulse marks a
 * re-power of the drive that keeps parameter contents.
 */
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
`include "simss_defs.svh"

module simss_top
    import simss_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [8:0]  digital_in,
    input  wire logic        set_key_press,
    input  wire logic        mode_key_press,
    input  wire logic        power_cycle_pulse,
    input  wire logic [31:0] analog_speed_ref,
    input  wire logic [31:0] motor_speed,
    output logic             servo_on,
    output logic             jog_active,
    output logic             emg_warning,
    output logic             neg_limit_warning,
    output logic             pos_limit_warning,
    output logic             alarm_pending,
    output logic             torque_clamp,
    output logic             speed_mode_active,
    output logic      [31:0] speed_cmd,
    output logic      [31:0] display_value,
    output logic             display_speed
);

    ////////////////////////////////////////////////////////////////////
    // Input function decode

    simss_state_t q;
    simss_state_t nxt;
    logic [7:0]   fon;

    simss_di_decode u_decode
    (
        .fn_code (q.fn_code),
        .di      (digital_in),
        .func_on (fon)
    );

    ////////////////////////////////////////////////////////////////////
    // Next state

    logic        bus_req;
    logic        bus_wr;
    logic [7:0]  word_adr;
    logic [31:0] merged;
    logic [31:0] cand;
    logic [31:0] sel_cmd;
    logic        warn_any;

    always_comb
    begin
        nxt      = q;
        bus_req  = wb_cyc_i && wb_stb_i && !q.ack;
        bus_wr   = bus_req && wb_we_i;
        word_adr = {wb_adr_i[7:2], 2'h0};
        merged   = 32'h00000000;
        cand     = 32'h00000000;
        sel_cmd  = 32'h00000000;

        // Bus answer one cycle after the request, dropped the next
        nxt.ack   = bus_req;
        nxt.rdata = 32'h00000000;
        if (bus_req)
        begin
            for (int k = 0; k < 8; k++)
                if (word_adr == `SIMSS_OFF_FN_BASE + 8'(4 * k))
                    nxt.rdata = {16'h0000, q.fn_code[k]};
            unique case (word_adr)
                `SIMSS_OFF_FN9:    nxt.rdata = {16'h0000, q.fn_code[8]};
                `SIMSS_OFF_SW_EN:  nxt.rdata = {31'h00000000, q.sw_en};
                `SIMSS_OFF_JOG:    nxt.rdata = {16'h0000, q.jog_speed};
                `SIMSS_OFF_MODE:   nxt.rdata = {24'h000000, q.mode_active,
                                                q.mode_param};
                `SIMSS_OFF_SPEED_SELECT_HIGH:   nxt.rdata = q.spd_reg[0];
                `SIMSS_OFF_SPD2:   nxt.rdata = q.spd_reg[1];
                `SIMSS_OFF_SPD3:   nxt.rdata = q.spd_reg[2];
                `SIMSS_OFF_DISP:   nxt.rdata = {16'h0000, q.disp_param};
                `SIMSS_OFF_STATUS: nxt.rdata = {16'h0000, q.mode_active,
                                     q.src, q.speed_cmd != 32'h00000000,
                                     q.trq, q.jog == SIMSS_JOG_RUN,
                                     q.servo_on, q.alarm, q.warn_pl,
                                     q.warn_nl, q.warn_emg};
                `SIMSS_OFF_CMD:    nxt.rdata = q.speed_cmd;
                default:           ;
            endcase
        end

        // Register writes, byte lanes honoured
        if (bus_wr)
        begin
            for (int k = 0; k < 8; k++)
                if (word_adr == `SIMSS_OFF_FN_BASE + 8'(4 * k))
                begin
                    merged = simss_merge({16'h0000, q.fn_code[k]},
                                         wb_dat_i, wb_sel_i);
                    nxt.fn_code[k] = merged[15:0];
                end
            unique case (word_adr)
                `SIMSS_OFF_FN9:
                begin
                    merged = simss_merge({16'h0000, q.fn_code[8]},
                                         wb_dat_i, wb_sel_i);
                    nxt.fn_code[8] = merged[15:0];
                end
                `SIMSS_OFF_SW_EN:
                    if (wb_sel_i[0])
                        nxt.sw_en = wb_dat_i[0];
                `SIMSS_OFF_JOG:
                begin
                    merged = simss_merge({16'h0000, q.jog_speed},
                                         wb_dat_i, wb_sel_i);
                    nxt.jog_speed = merged[15:0];
                    nxt.jog_armed = 1'b1;
                end
                `SIMSS_OFF_MODE:
                    if (wb_sel_i[0])
                        nxt.mode_param = wb_dat_i[3:0];
                `SIMSS_OFF_SPEED_SELECT_HIGH, `SIMSS_OFF_SPD2, `SIMSS_OFF_SPD3:
                begin
                    for (int r = 0; r < 3; r++)
                        if (word_adr == `SIMSS_OFF_SPEED_SELECT_HIGH + 8'(4 * r))
                        begin
                            cand = simss_merge(q.spd_reg[r], wb_dat_i,
                                               wb_sel_i);
                            if ($signed(cand) > `SIMSS_SPD_MAX)
                                cand = `SIMSS_SPD_MAX;
                            else if ($signed(cand) < `SIMSS_SPD_MIN)
                                cand = `SIMSS_SPD_MIN;
                            nxt.spd_reg[r] = cand;
                        end
                end
                `SIMSS_OFF_DISP:
                begin
                    merged = simss_merge({16'h0000, q.disp_param},
                                         wb_dat_i, wb_sel_i);
                    nxt.disp_param = merged[15:0];
                end
                default: ;
            endcase
        end

        // Warnings follow the decoded inputs every cycle
        nxt.warn_emg = fon[SIMSS_FI_EMG];
        nxt.warn_nl  = fon[SIMSS_FI_NL];
        nxt.warn_pl  = fon[SIMSS_FI_PL];
        nxt.trq      = fon[SIMSS_FI_TRQ];
        warn_any     = fon[SIMSS_FI_EMG] || fon[SIMSS_FI_NL] ||
                       fon[SIMSS_FI_PL];

        // A warning present in the clearing cycle keeps the alarm
        nxt.alarm = warn_any ||
                    (q.alarm && !fon[SIMSS_FI_ALARM_CLEAR_INPUT] &&
                     !power_cycle_pulse);

        nxt.servo_on = (q.sw_en || fon[SIMSS_FI_SON]) &&
                       !q.alarm;

        // Mode parameter only takes hold at re-power
        if (power_cycle_pulse)
            nxt.mode_active = q.mode_param;
        nxt.spd_mode = (nxt.mode_active == `SIMSS_MODE_SPEED);

        // Jog entry and exit
        unique case (q.jog)
            SIMSS_JOG_IDLE:
                if (set_key_press && q.jog_armed && !power_cycle_pulse)
                    nxt.jog = SIMSS_JOG_RUN;
            SIMSS_JOG_RUN:
                if (mode_key_press || power_cycle_pulse)
                    nxt.jog = SIMSS_JOG_IDLE;
            default:
                nxt.jog = SIMSS_JOG_IDLE;
        endcase

        // Source follows select levels with no other action
        unique case ({fon[SIMSS_FI_SPEED_SELECT_HIGH], fon[SIMSS_FI_SPEED_SELECT_LOW]})
            2'h0: nxt.src = SIMSS_SRC_ANALOG;
            2'h1: nxt.src = SIMSS_SRC_REG1;
            2'h2: nxt.src = SIMSS_SRC_REG2;
            2'h3: nxt.src = SIMSS_SRC_REG3;
        endcase

        unique case (q.src)
            SIMSS_SRC_ANALOG: sel_cmd = analog_speed_ref;
            SIMSS_SRC_REG1:   sel_cmd = q.spd_reg[0];
            SIMSS_SRC_REG2:   sel_cmd = q.spd_reg[1];
            SIMSS_SRC_REG3:   sel_cmd = q.spd_reg[2];
            default:          sel_cmd = 32'h00000000;
        endcase

        // Command in 0.1 r/min; zero while servo off
        if (!q.servo_on)
            nxt.speed_cmd = 32'h00000000;
        else if (q.jog == SIMSS_JOG_RUN)
            nxt.speed_cmd = {16'h0000, q.jog_speed} *
                            `SIMSS_JOG_SCALE;
        else if (q.mode_active == `SIMSS_MODE_SPEED)
            nxt.speed_cmd = sel_cmd;
        else
            nxt.speed_cmd = 32'h00000000;

        nxt.disp_spd = (q.disp_param == `SIMSS_DISP_SPEED);
        nxt.disp_val = nxt.disp_spd ? motor_speed : 32'h00000000;
    end

    ////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q             <= '0;
            q.fn_code     <= {`SIMSS_RST_FN9, `SIMSS_RST_FN8,
                              `SIMSS_RST_FN7, `SIMSS_RST_FN6,
                              `SIMSS_RST_FN5, `SIMSS_RST_FN4,
                              `SIMSS_RST_FN3, `SIMSS_RST_FN2,
                              `SIMSS_RST_FN1};
            q.jog_speed   <= `SIMSS_RST_JOG;
            q.mode_param  <= `SIMSS_RST_MODE;
            q.mode_active <= `SIMSS_RST_MODE;
            q.disp_param  <= `SIMSS_RST_DISP;
            q.jog         <= SIMSS_JOG_IDLE;
            q.src         <= SIMSS_SRC_ANALOG;
        end
        else
        begin
            q <= nxt;
        end
    end

    assign wb_ack_o          = q.ack;
    assign wb_dat_o          = q.rdata;
    assign servo_on          = q.servo_on;
    // Run code of the one-hot jog state is bit one
    assign jog_active        = q.jog[1];
    assign emg_warning       = q.warn_emg;
    assign neg_limit_warning = q.warn_nl;
    assign pos_limit_warning = q.warn_pl;
    assign alarm_pending     = q.alarm;
    assign torque_clamp      = q.trq;
    assign speed_mode_active = q.spd_mode;
    assign speed_cmd         = q.speed_cmd;
    assign display_value     = q.disp_val;
    assign display_speed     = q.disp_spd;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_jog_enter;
        q.jog == SIMSS_JOG_IDLE && q.jog_armed && set_key_press &&
        !power_cycle_pulse;
    endsequence

    sequence s_jog_leave;
        q.jog == SIMSS_JOG_RUN && mode_key_press;
    endsequence

    AST_ACK_PULSE: assert property
        (wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");

    AST_EMG_WARN: assert property
        (fon[SIMSS_FI_EMG] |=> emg_warning)
        else $error("halt input active but no warning");

    AST_NL_WARN: assert property
        (fon[SIMSS_FI_NL] != $past(fon[SIMSS_FI_NL]) |=>
         neg_limit_warning == $past(fon[SIMSS_FI_NL]))
        else $error("negative limit warning wrong");

    AST_PL_WARN: assert property
        (!fon[SIMSS_FI_PL] ##1 fon[SIMSS_FI_PL] |=> pos_limit_warning)
        else $error("positive limit warning missed");

    AST_SW_ENABLE: assert property
        (q.sw_en && !q.alarm |=> servo_on)
        else $error("software enable did not turn servo on");

    AST_JOG_ENTER: assert property
        (s_jog_enter |=> jog_active ##1 (!$past(servo_on) ||
         speed_cmd == {16'h0000, $past(q.jog_speed)} * `SIMSS_JOG_SCALE))
        else $error("set key did not enter jog");

    AST_JOG_LEAVE: assert property
        (s_jog_leave |=> !jog_active)
        else $error("mode key did not leave jog");

    AST_MODE_HOLD: assert property
        (!power_cycle_pulse |=> $stable(q.mode_active))
        else $error("control mode changed without power cycle");

    AST_SRC_REG3: assert property
        (fon[SIMSS_FI_SPEED_SELECT_HIGH] && fon[SIMSS_FI_SPEED_SELECT_LOW] && q.servo_on &&
         q.jog == SIMSS_JOG_IDLE && speed_mode_active ##1
         q.servo_on && q.jog == SIMSS_JOG_IDLE
         |=> speed_cmd == $past(q.spd_reg[2]))
        else $error("third register not selected");

    AST_ALARM_CLEAR: assert property
        (q.alarm && power_cycle_pulse && !fon[SIMSS_FI_EMG] &&
         !fon[SIMSS_FI_NL] && !fon[SIMSS_FI_PL] |=> !alarm_pending)
        else $error("alarm survived power cycle");

    AST_SERVO_OFF: assert property
        (!servo_on |=> speed_cmd == 32'h00000000)
        else $error("speed commanded while servo off");

    AST_DISPLAY: assert property
        (q.disp_param == `SIMSS_DISP_SPEED |=>
         display_speed && display_value == $past(motor_speed))
        else $error("display not showing motor speed");

endmodule : simss_top
`default_nettype wire

// >>> testbench/simss_switch_model.sv
/*
 * Switch panel model: drives the nine digital input levels.
 * Assumes clock and rst_b of the block under test.
 */
`timescale 1ns/1ns
`default_nettype none
module simss_switch_model
(
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic [8:0] sw_req,
    output logic      [8:0] digital_in
);
    // Contacts follow the operator one clock late
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            digital_in <= 9'h000;
        else
            digital_in <= sw_req;
    end
endmodule : simss_switch_model
`default_nettype wire

// >>> testbench/tb_top.sv
/*
 * Self-checking bench of simss_top with a switch panel model.
 * Assumes a 250 MHz clock and classic Wishbone answers.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import simss_pkg::*;
    logic clock = 0, rst_b = 0, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, analog_speed_ref = 32'h123;
    logic [31:0] motor_speed = 32'h55, wb_dat_o, speed_cmd, display_value;
    logic [3:0] wb_sel_i = 4'hF;
    logic [8:0] sw = 9'h000, digital_in;
    logic set_key_press = 0, mode_key_press = 0, power_cycle_pulse = 0;
    logic wb_ack_o, servo_on, jog_active, emg_warning, neg_limit_warning;
    logic pos_limit_warning, alarm_pending, torque_clamp, speed_mode_active;
    logic display_speed;
    logic [31:0] q;
    int num_errors = 0, checked = 0;
    logic [33:0] rows [5] = '{{2'h0, 32'h123}, {2'h1, 32'h7530},
        {2'h2, 32'h3E8}, {2'h3, 32'hFFFF8AD0}, {2'h0, 32'h123}};

    always #2 clock = ~clock;

    simss_switch_model u_sw (.clock, .rst_b, .sw_req(sw), .digital_in);
    simss_top DUT (.clock, .rst_b, .wb_adr_i, .wb_dat_i, .wb_sel_i,
        .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .digital_in,
        .set_key_press, .mode_key_press, .power_cycle_pulse,
        .analog_speed_ref, .motor_speed, .servo_on, .jog_active,
        .emg_warning, .neg_limit_warning, .pos_limit_warning,
        .alarm_pending, .torque_clamp, .speed_mode_active, .speed_cmd,
        .display_value, .display_speed);

    ////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        // Ack and read data taken at the rising edge that shows ack
        do
        begin
            @(posedge clock);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        if (wb_ack_o !== 1'b1)
            num_errors++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb

    task automatic setsw(input logic [8:0] v);
        @(posedge clock);
        sw <= v;
        repeat (6) @(negedge clock);
    endtask : setsw

    // One-cycle pulse on {power cycle, set key, mode key}
    task automatic pulse(input logic [2:0] which);
        @(posedge clock);
        {power_cycle_pulse, set_key_press, mode_key_press} <= which;
        @(posedge clock);
        {power_cycle_pulse, set_key_press, mode_key_press} <= 3'h0;
        repeat (4) @(negedge clock);
    endtask : pulse

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (15) @(posedge clock);
        @(negedge clock);
        chk(32'({alarm_pending, servo_on, emg_warning}), 32'h0);
        @(posedge clock);
        rst_b <= 1;
        repeat (4) @(negedge clock);
        chk(32'({emg_warning, neg_limit_warning, pos_limit_warning}),
            32'h7);
        wb(0, 8'h14, 0); chk(q, 32'h22);
        wb(0, 8'h18, 0); chk(q, 32'h23);
        wb(0, 8'h1C, 0); chk(q, 32'h21);
        setsw(9'h0E0); chk(32'(neg_limit_warning), 32'h0);
        chk(32'(alarm_pending), 32'h1);
        setsw(9'h0F0); chk(32'(alarm_pending), 32'h0);
        setsw(9'h0E1); chk(32'(servo_on), 32'h1);
        setsw(9'h0E0); chk(32'(servo_on), 32'h0);
        wb(1, 8'h24, 1); setsw(9'h0E0); chk(32'(servo_on), 32'h1);
        wb(1, 8'h2C, 2); setsw(9'h0E0);
        chk(32'(speed_mode_active), 32'h0);
        chk(speed_cmd, 32'h0);
        pulse(3'h4); chk(32'(speed_mode_active), 1);
        wb(1, 8'h30, 32'h7530); wb(1, 8'h34, 32'h3E8);
        wb(1, 8'h38, 32'hFFFF8AD0);
        foreach (rows[i])
        begin
            setsw({4'h7, 1'b0, rows[i][33:32], 2'h0});
            chk(speed_cmd, rows[i][31:0]);
        end
        wb(1, 8'h30, 32'hEA60); wb(0, 8'h30, 0); chk(q, 32'hC350);
        wb(1, 8'h34, 32'hFFFF15A0); wb(0, 8'h34, 0);
        chk(q, 32'hFFFF3CB0);
        setsw(9'h0E2); chk(32'(torque_clamp), 32'h1);
        wb(1, 8'h14, 32'h122); setsw(9'h0E0);
        chk(32'(neg_limit_warning), 32'h1);
        setsw(9'h0F0); chk(32'(alarm_pending), 32'h1);
        setsw(9'h0C0); chk(32'(neg_limit_warning), 32'h0);
        chk(speed_cmd, 32'h0);
        wb(1, 8'h1C, 0); setsw(9'h040); chk(32'(emg_warning), 0);
        wb(1, 8'h20, 32'h121); setsw(9'h140);
        chk(32'(emg_warning), 32'h1);
        wb(1, 8'h18, 32'h123); setsw(9'h140);
        chk(32'(pos_limit_warning), 32'h1);
        setsw(9'h010); setsw(9'h000); chk(32'(alarm_pending), 0);
        wb(1, 8'h28, 32'h64); pulse(3'h2);
        chk(32'(jog_active), 32'h1);
        chk(speed_cmd, 32'h3E8);
        pulse(3'h1); chk(32'(jog_active), 32'h0);
        wb(1, 8'h3C, 6); setsw(9'h000); chk(display_value, 32'h55);
        chk(32'(display_speed), 32'h1);
        wb(0, 8'h80, 0); chk(q, 32'h0);
        // Second reset in mid-run restores parameter defaults
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(negedge clock);
        chk(32'({alarm_pending, servo_on, jog_active, display_speed}),
            32'h0);
        @(posedge clock);
        rst_b <= 1'b1;
        wb(0, 8'h1C, 0); chk(q, 32'h21);
        final_report();
    end

    initial
    begin
        repeat (3000) @(posedge clock);
        num_errors++;
        final_report();
    end
endmodule : tb_top
`default_nettype wire
